// file: flag_branch_pkg.sv
// constants, opcodes and register map for the bit invert and flag branch executor
// Summary of operation
// - top nibble 0111 decodes as bit invert
// - read location, invert one bit, write back
// - select zero: access bank; one: bank register
// - extended set, select zero, f<=95: indexed offset
// - upper byte e4 decodes as branch on overflow
// - overflow one branches; otherwise next instruction
// - upper byte e0 branches when zero is one
// - target is address plus two plus 2n
// - taken branch adds one no-operation cycle
`default_nettype none
package flag_branch_pkg;
    localparam int PC_W   = 21;
    localparam int ADDR_W = 12;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_t;

    typedef enum logic [2:0] {
        OP_NOP      = 3'b000,
        OP_INVERT   = 3'b001,
        OP_BR_OV    = 3'b010,
        OP_BR_ZERO  = 3'b011,
        OP_SKIP_CLR = 3'b100,
        OP_SKIP_SET = 3'b101
    } op_t;

    localparam logic [3:0] BIT_INVERT_NIB   = 4'h7;
    localparam logic [3:0] SKIP_SET_NIB     = 4'ha;
    localparam logic [3:0] SKIP_CLR_NIB     = 4'hb;
    localparam logic [7:0] BR_OV_BYTE       = 8'he4;
    localparam logic [7:0] BR_ZERO_BYTE     = 8'he0;
    localparam logic [3:0] TWO_WORD_NIB     = 4'hc;
    localparam logic [6:0] TWO_WORD_E_HI    = 7'h76;
    localparam logic [7:0] INDEXED_LIMIT    = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT     = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [PC_W-1:0] PC_STEP     = 21'h000002;

    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_BANK   = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_PC     = 12'h00c;
    localparam logic [11:0] OFS_INDEX  = 12'h010;
    localparam logic [11:0] OFS_CYCLES = 12'h014;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;

    localparam logic [1:0]      CTRL_RESET  = 2'h0;
    localparam logic [3:0]      BANK_RESET  = 4'h0;
    localparam logic [ADDR_W-1:0] INDEX_RESET = 12'h000;
    localparam logic [PC_W-1:0] PC_RESET    = 21'h000000;
endpackage : flag_branch_pkg
`default_nettype wire

// file: data_addr_former.sv
// data memory address former for byte and bit oriented operands
`default_nettype none
module data_addr_former
(
    input  wire logic [7:0]                         fileAddr,
    input  wire logic                               accessSel,
    input  wire logic                               extEnable,
    input  wire logic [3:0]                         bankSelect,
    input  wire logic [flag_branch_pkg::ADDR_W-1:0] indexBase,
    output logic      [flag_branch_pkg::ADDR_W-1:0] dataAddr,
    output logic                                    indexed
);
    import flag_branch_pkg::*;

    always_comb begin
        indexed = !accessSel && extEnable && (fileAddr <= INDEXED_LIMIT);
        if (indexed) begin
            dataAddr = indexBase + {4'h0, fileAddr};
        end else if (accessSel) begin
            dataAddr = {bankSelect, fileAddr};
        end else if (fileAddr < ACCESS_SPLIT) begin
            dataAddr = {4'h0, fileAddr};
        end else begin
            dataAddr = {ACCESS_HIGH_BANK, fileAddr};
        end
    end
endmodule : data_addr_former
`default_nettype wire

// file: flag_branch_exec.sv
// instruction executor: bit invert, flag branches and skip flushing
//
// The implementer's own choices: the placing of the registers and the APB register port.
`default_nettype none
module flag_branch_exec
(
    input  wire logic                           clk,
    input  wire logic                           rstn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [11:0]                    paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [15:0]                    instr,
    output logic      [flag_branch_pkg::PC_W-1:0]   progAddr,
    input  wire logic                           flagOv,
    input  wire logic                           flagZero,
    output logic      [flag_branch_pkg::ADDR_W-1:0] memAddr,
    output logic                                memRd,
    output logic                                memWr,
    output logic      [7:0]                     memWdata,
    input  wire logic [7:0]                     memRdata
);
    import flag_branch_pkg::*;

    // register file
    logic [1:0]        ctrl;
    logic [3:0]        bank_select_register;
    logic [ADDR_W-1:0] indexBase;
    logic [31:0]       cycles;
    logic [1:0]        next_ctrl;
    logic [3:0]        next_bank;
    logic [ADDR_W-1:0] next_indexBase;
    logic [31:0]       next_cycles;
    logic [31:0]       next_prdata;
    logic              next_pslverr;
    logic              wrEn;

    // execution state
    phase_t            phase;
    op_t               curOp;
    logic [15:0]       curInstr;
    logic [PC_W-1:0]   pc;
    logic [PC_W-1:0]   instrAddr;
    logic [7:0]        readData;
    logic              taken;
    logic              flushNop;
    logic              skipPending;
    logic              extraNop;
    logic              lastTaken;
    phase_t            next_phase;
    op_t               next_curOp;
    logic [15:0]       next_curInstr;
    logic [PC_W-1:0]   next_pc;
    logic [PC_W-1:0]   next_instrAddr;
    logic [7:0]        next_readData;
    logic              next_taken;
    logic              next_flushNop;
    logic              next_skipPending;
    logic              next_extraNop;
    logic              next_lastTaken;
    logic [ADDR_W-1:0] next_memAddr;
    logic              next_memRd;
    logic              next_memWr;
    logic [7:0]        next_memWdata;

    logic [ADDR_W-1:0] formedAddr;
    logic              formedIndexed;
    logic              running;
    logic [7:0]        bitMask;
    logic              bitValue;
    logic              twoWord;
    logic [PC_W-1:0]   branchTarget;
    op_t               decoded;

    assign running  = ctrl[CTRL_RUN_BIT];
    assign progAddr = pc;
    assign pready   = 1'b1;
    assign bitMask  = 8'h01 << curInstr[11:9];
    assign bitValue = |(readData & bitMask);
    assign twoWord  = (instr[15:12] == TWO_WORD_NIB) || (instr[15:9] == TWO_WORD_E_HI)
                   || (instr[15:8] == 8'hee) || (instr[15:8] == 8'hef);
    assign branchTarget = instrAddr + PC_STEP
                        + {{(PC_W-9){curInstr[7]}}, curInstr[7:0], 1'b0};

    data_addr_former u_addr (
        .fileAddr   (curInstr[7:0]),
        .accessSel  (curInstr[8]),
        .extEnable  (ctrl[CTRL_EXT_BIT]),
        .bankSelect (bank_select_register),
        .indexBase  (indexBase),
        .dataAddr   (formedAddr),
        .indexed    (formedIndexed)
    );

    // opcode decode
    always_comb begin
        if (instr[15:12] == BIT_INVERT_NIB) begin
            decoded = OP_INVERT;
        end else if (instr[15:8] == BR_OV_BYTE) begin
            decoded = OP_BR_OV;
        end else if (instr[15:8] == BR_ZERO_BYTE) begin
            decoded = OP_BR_ZERO;
        end else if (instr[15:12] == SKIP_CLR_NIB) begin
            decoded = OP_SKIP_CLR;
        end else if (instr[15:12] == SKIP_SET_NIB) begin
            decoded = OP_SKIP_SET;
        end else begin
            decoded = OP_NOP;
        end
    end

    // apb slave
    always_comb begin
        wrEn           = psel && penable && pwrite;
        next_ctrl      = ctrl;
        next_bank      = bank_select_register;
        next_indexBase = indexBase;
        next_cycles    = (running && phase == PH_Q4) ? cycles + 32'h1 : cycles;
        next_prdata    = prdata;
        next_pslverr   = pslverr;
        if (psel && !penable) begin
            next_prdata = 32'h0;
            if (paddr == OFS_CTRL) begin
                next_prdata = {30'h0, ctrl};
            end else if (paddr == OFS_BANK) begin
                next_prdata = {28'h0, bank_select_register};
            end else if (paddr == OFS_STATUS) begin
                next_prdata = {24'h0, curOp, phase, lastTaken, skipPending, flushNop};
            end else if (paddr == OFS_PC) begin
                next_prdata = {11'h0, pc};
            end else if (paddr == OFS_INDEX) begin
                next_prdata = {20'h0, indexBase};
            end else if (paddr == OFS_CYCLES) begin
                next_prdata = cycles;
            end
        end
        if (psel && !penable) begin
            next_pslverr = !(paddr == OFS_CTRL || paddr == OFS_BANK || paddr == OFS_STATUS
                          || paddr == OFS_PC || paddr == OFS_INDEX || paddr == OFS_CYCLES);
        end
        if (wrEn && paddr == OFS_CTRL) begin
            next_ctrl = pwdata[1:0];
        end else if (wrEn && paddr == OFS_BANK) begin
            next_bank = pwdata[3:0];
        end else if (wrEn && paddr == OFS_INDEX) begin
            next_indexBase = pwdata[ADDR_W-1:0];
        end
    end

    // four phase execution
    always_comb begin
        next_phase       = phase;
        next_curOp       = curOp;
        next_curInstr    = curInstr;
        next_pc          = pc;
        next_instrAddr   = instrAddr;
        next_readData    = readData;
        next_taken       = taken;
        next_flushNop    = flushNop;
        next_skipPending = skipPending;
        next_extraNop    = extraNop;
        next_lastTaken   = lastTaken;
        next_memAddr     = memAddr;
        next_memRd       = 1'b0;
        next_memWr       = 1'b0;
        next_memWdata    = memWdata;
        if (running) begin
            case (phase)
                PH_Q1: begin
                    next_phase = PH_Q2;
                    next_taken = 1'b0;
                    if (flushNop) begin
                        next_curOp    = OP_NOP;
                        next_flushNop = 1'b0;
                    end else if (skipPending) begin
                        next_curOp       = OP_NOP;
                        next_pc          = pc + PC_STEP;
                        next_skipPending = 1'b0;
                        next_extraNop    = twoWord;
                    end else if (extraNop) begin
                        next_curOp    = OP_NOP;
                        next_pc       = pc + PC_STEP;
                        next_extraNop = 1'b0;
                    end else begin
                        next_curOp     = decoded;
                        next_curInstr  = instr;
                        next_instrAddr = pc;
                        next_pc        = pc + PC_STEP;
                    end
                end
                PH_Q2: begin
                    next_phase = PH_Q3;
                    next_memAddr = formedAddr;
                    next_memRd   = (curOp == OP_INVERT) || (curOp == OP_SKIP_CLR)
                                || (curOp == OP_SKIP_SET);
                end
                PH_Q3: begin
                    next_phase    = PH_Q4;
                    next_readData = memRdata;
                    case (curOp)
                        OP_BR_OV:   next_taken = flagOv;
                        OP_BR_ZERO: next_taken = flagZero;
                        OP_INVERT: begin
                            next_memWdata = memRdata ^ bitMask;
                            next_memWr    = 1'b1;
                        end
                        default:    next_taken = 1'b0;
                    endcase
                end
                default: begin
                    next_phase = PH_Q1;
                    if (curOp == OP_BR_OV || curOp == OP_BR_ZERO) begin
                        next_lastTaken = taken;
                        if (taken) begin
                            next_pc       = branchTarget;
                            next_flushNop = 1'b1;
                        end
                    end else if (curOp == OP_SKIP_CLR) begin
                        next_skipPending = !bitValue;
                    end else if (curOp == OP_SKIP_SET) begin
                        next_skipPending = bitValue;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl                 <= CTRL_RESET;
            bank_select_register <= BANK_RESET;
            indexBase            <= INDEX_RESET;
            cycles               <= 32'h0;
            prdata               <= 32'h0;
            pslverr              <= 1'b0;
            phase                <= PH_Q1;
            curOp                <= OP_NOP;
            curInstr             <= 16'h0;
            pc                   <= PC_RESET;
            instrAddr            <= PC_RESET;
            readData             <= 8'h0;
            taken                <= 1'b0;
            flushNop             <= 1'b0;
            skipPending          <= 1'b0;
            extraNop             <= 1'b0;
            lastTaken            <= 1'b0;
            memAddr              <= '0;
            memRd                <= 1'b0;
            memWr                <= 1'b0;
            memWdata             <= 8'h0;
        end else begin
            ctrl                 <= next_ctrl;
            bank_select_register <= next_bank;
            indexBase            <= next_indexBase;
            cycles               <= next_cycles;
            prdata               <= next_prdata;
            pslverr              <= next_pslverr;
            phase                <= next_phase;
            curOp                <= next_curOp;
            curInstr             <= next_curInstr;
            pc                   <= next_pc;
            instrAddr            <= next_instrAddr;
            readData             <= next_readData;
            taken                <= next_taken;
            flushNop             <= next_flushNop;
            skipPending          <= next_skipPending;
            extraNop             <= next_extraNop;
            lastTaken            <= next_lastTaken;
            memAddr              <= next_memAddr;
            memRd                <= next_memRd;
            memWr                <= next_memWr;
            memWdata             <= next_memWdata;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_phase_order: assert property (running && phase == PH_Q1 |=> phase == PH_Q2)
        else $error("phase did not advance from decode to read");
    a_write_in_q4: assert property (memWr |-> phase == PH_Q4 && curOp == OP_INVERT)
        else $error("data write outside write-back phase");
    a_invert_data: assert property (memWr |-> memWdata == ($past(memRdata) ^ bitMask))
        else $error("inverted data wrong");
    a_decode_invert: assert property (phase == PH_Q2 && curOp == OP_INVERT
        |-> curInstr[15:12] == 4'h7)
        else $error("invert decoded from wrong opcode");
    a_bank_addr: assert property (phase == PH_Q3 && curOp == OP_INVERT && curInstr[8]
        |-> memAddr == {bank_select_register, curInstr[7:0]})
        else $error("banked address wrong");
    a_indexed_addr: assert property (phase == PH_Q3 && curOp == OP_INVERT
        && !curInstr[8] && ctrl[CTRL_EXT_BIT] && curInstr[7:0] <= 8'h5f
        |-> memAddr == indexBase + {4'h0, curInstr[7:0]})
        else $error("indexed address wrong");
    a_ov_taken: assert property (phase == PH_Q4 && curOp == OP_BR_OV && taken
        |=> pc == $past(branchTarget))
        else $error("overflow branch target wrong");
    a_zero_fall: assert property (phase == PH_Q4 && curOp == OP_BR_ZERO && !taken
        |=> pc == $past(instrAddr) + 21'h000002)
        else $error("untaken zero branch moved pc");
    a_flush_stall: assert property (phase == PH_Q4 && taken && running
        |-> ##2 $stable(pc)[*4] ##1 pc == $past(pc) + 21'h000002)
        else $error("taken branch no-operation cycle wrong");
    a_skip_nop: assert property (skipPending && running && phase == PH_Q1
        |=> curOp == OP_NOP)
        else $error("skipped word was executed");

    c_invert: cover property (memWr);
    c_ov_taken: cover property (phase == PH_Q4 && curOp == OP_BR_OV && taken);
    c_zero_not: cover property (phase == PH_Q4 && curOp == OP_BR_ZERO && !taken);
    c_skip_two: cover property (extraNop && phase == PH_Q1);
    c_indexed: cover property (phase == PH_Q3 && formedIndexed);
endmodule : flag_branch_exec
`default_nettype wire

// file: testbench.sv
// self-checking bench for the bit invert and flag branch executor
`default_nettype none
module testbench
    import flag_branch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clk;
    logic              rstn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [15:0]       instr;
    logic [PC_W-1:0]   progAddr;
    logic              flagOv;
    logic              flagZero;
    logic [ADDR_W-1:0] memAddr;
    logic              memRd;
    logic              memWr;
    logic [7:0]        memWdata;
    logic [7:0]        memRdata;
    logic [15:0]       baseWord;
    logic [15:0]       followWord;
    int                numErrors;
    int                checkCount;

    flag_branch_exec dut_u (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr(instr), .progAddr(progAddr), .flagOv(flagOv),
        .flagZero(flagZero), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
        .memWdata(memWdata), .memRdata(memRdata)
    );

    always #50 clk = ~clk;

    // program word at the current fetch address
    always @(posedge clk) begin
        instr <= (progAddr == 21'h000002) ? followWord : baseWord;
    end

    task automatic tallyAndFinish();
        if (numErrors == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tallyAndFinish

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic giveUp(input string what);
        numErrors++;
        $display("[FAIL] %s expected event seen timeout", what);
        tallyAndFinish();
    endtask : giveUp

    // apb transfer: setup, access until pready, then release
    task automatic apbXfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                           output logic [31:0] rdata, output logic err);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) giveUp("pready");
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apbXfer

    task automatic apbWrite(input logic [11:0] addr, input logic [31:0] wdata);
        logic [31:0] rd;
        logic        err;
        apbXfer(1'b1, addr, wdata, rd, err);
    endtask : apbWrite

    // reset, present program word and flags, then configure and run
    task automatic startCore(input logic [15:0] word, input logic [7:0] rd, input logic ov,
                             input logic z, input logic [31:0] ctrl, input logic [3:0] bank,
                             input logic [11:0] base);
        @(posedge clk);
        rstn     <= 1'b0;
        baseWord   <= word;
        followWord <= word;
        memRdata <= rd;
        flagOv   <= ov;
        flagZero <= z;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        apbWrite(OFS_BANK, {28'h0, bank});
        apbWrite(OFS_INDEX, {20'h0, base});
        apbWrite(OFS_CTRL, ctrl);
    endtask : startCore

    task automatic waitPcMove(output int clocks, output logic [PC_W-1:0] pcNow);
        logic [PC_W-1:0] pcOld;
        pcOld  = progAddr;
        clocks = 0;
        do begin
            @(negedge clk);
            clocks++;
        end while (progAddr === pcOld && clocks < 40);
        if (clocks >= 40) giveUp("progAddr move");
        pcNow = progAddr;
    endtask : waitPcMove

    task automatic waitMemRd(output int clocks);
        clocks = 0;
        do begin
            @(negedge clk);
            clocks++;
        end while (memRd !== 1'b1 && clocks < 60);
        if (clocks >= 60) giveUp("memRd");
    endtask : waitMemRd

    task automatic regCheck();
        logic [31:0] rd;
        logic        err;
        apbXfer(1'b0, OFS_CTRL, 32'h0, rd, err);
        check("ctrl reset", 32'h0, rd);
        apbXfer(1'b0, 12'h040, 32'h0, rd, err);
        check("unmapped read", 32'h0, rd);
        check("unmapped slverr", 32'h1, {31'h0, err});
        apbWrite(OFS_BANK, 32'hffffffff);
        apbXfer(1'b0, OFS_BANK, 32'h0, rd, err);
        check("bank width", 32'h0000000f, rd);
        check("mapped slverr", 32'h0, {31'h0, err});
        apbWrite(OFS_INDEX, 32'hffffffff);
        apbXfer(1'b0, OFS_INDEX, 32'h0, rd, err);
        check("index width", 32'h00000fff, rd);
        apbWrite(OFS_PC, 32'h00001234);
        apbXfer(1'b0, OFS_PC, 32'h0, rd, err);
        check("pc read only", 32'h0, rd);
    endtask : regCheck

    task automatic invertCase(input logic [15:0] word, input logic [7:0] rd,
                              input logic [31:0] ctrl, input logic [3:0] bank,
                              input logic [11:0] base, input logic [11:0] expAddr,
                              input logic [7:0] expData);
        int c;
        startCore(word, rd, 1'b0, 1'b0, ctrl, bank, base);
        waitMemRd(c);
        check("read cycle", 32'd3, c);
        check("memAddr", {20'h0, expAddr}, {20'h0, memAddr});
        @(negedge clk);
        check("memRd width", 32'h0, {31'h0, memRd});
        check("memWr", 32'h1, {31'h0, memWr});
        check("memWdata", {24'h0, expData}, {24'h0, memWdata});
        @(negedge clk);
        check("memWr width", 32'h0, {31'h0, memWr});
    endtask : invertCase

    task automatic branchCase(input logic [15:0] word, input logic ov, input logic z,
                              input logic taken);
        int              c1;
        int              c2;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] target;
        target = 21'h000002 + {{12{word[7]}}, word[7:0], 1'b0};
        startCore(word, 8'h00, ov, z, 32'h1, 4'h0, 12'h000);
        waitPcMove(c1, pc);
        check("pc after fetch", 32'h2, {11'h0, pc});
        waitPcMove(c1, pc);
        if (taken) begin
            check("branch target", {11'h0, target}, {11'h0, pc});
            waitPcMove(c2, pc);
            check("taken clocks", 32'd8, c1 + c2);
            check("fetch at target", {11'h0, target + 21'h2}, {11'h0, pc});
        end else begin
            check("fall through", 32'h4, {11'h0, pc});
            check("untaken clocks", 32'd4, c1);
        end
    endtask : branchCase

    task automatic skipCase(input logic [15:0] word, input logic [15:0] follow,
                            input logic [7:0] rd, input int gap);
        int c;
        startCore(word, rd, 1'b0, 1'b0, 32'h1, 4'h0, 12'h000);
        followWord <= follow;
        waitMemRd(c);
        waitMemRd(c);
        check("skip gap", gap, c);
    endtask : skipCase

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        baseWord = 16'h0000;
        followWord = 16'h0000;
        flagOv = 1'b0;
        flagZero = 1'b0;
        memRdata = 8'h00;
        numErrors = 0;
        checkCount = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        regCheck();
        invertCase(16'h7945, 8'h75, 32'h1, 4'h3, 12'h000, 12'h345, 8'h65);
        invertCase(16'h7e20, 8'h00, 32'h1, 4'h3, 12'h000, 12'h020, 8'h80);
        invertCase(16'h7080, 8'hff, 32'h1, 4'h0, 12'h000, 12'hf80, 8'hfe);
        invertCase(16'h725f, 8'h00, 32'h3, 4'h0, 12'h200, 12'h25f, 8'h02);
        invertCase(16'h7460, 8'h04, 32'h3, 4'h0, 12'h200, 12'hf60, 8'h00);
        invertCase(16'h7712, 8'ha5, 32'h3, 4'h5, 12'h200, 12'h512, 8'had);
        branchCase(16'he405, 1'b1, 1'b0, 1'b1);
        branchCase(16'he405, 1'b0, 1'b1, 1'b0);
        branchCase(16'he07f, 1'b0, 1'b1, 1'b1);
        branchCase(16'he080, 1'b0, 1'b1, 1'b1);
        branchCase(16'he07f, 1'b1, 1'b0, 1'b0);
        skipCase(16'ha810, 16'ha810, 8'h10, 8);
        skipCase(16'ha810, 16'ha810, 8'h00, 4);
        skipCase(16'hb810, 16'hb810, 8'h00, 8);
        skipCase(16'hb810, 16'hb810, 8'h10, 4);
        skipCase(16'ha810, 16'hc000, 8'h10, 12);
        tallyAndFinish();
    end
endmodule : testbench
`default_nettype wire
